// File: rtl/cce_clock_control.v
// clock control register, apb slave and clock gating logic
//
// Notes on behaviour
// - synth power bit low keeps pll powered down, output clock off.
// - pll output clock runs only when power and main gate both set.
// - two-wire inputs pass 50 ns glitch filter unless filter-off bit set.
// - in spi mode the glitch filter is always bypassed.
// - source select 0 picks external pin, 1 picks pll.
// - core divider bit 0 divides by two, 1 by one; core only.
// - master divider bit 0 divides by two, 1 by one; non-core logic.
// - main gate low: only clock control and pll setup writes accepted.
// - after main gate set, parameter writes blocked until dsp clock gate set.
// - clock control at index 0, resets to 0x00.
// - lock flag read-only in bit 0 of lock status at index 6.
//
// Implementation choice: the APB register port.
`include "cce_consts.vh"

module cce_clock_control (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire pll_lock_pin,
   input wire spi_mode_pin,
   input wire sda_pin,
   input wire scl_pin,
   output wire sda_filtered,
   output wire scl_filtered,
   output reg pll_power_up,
   output reg pll_clock_enable,
   output reg xtal_osc_disable,
   output reg main_source_select,
   output reg core_divider_select,
   output reg master_divider_select,
   output reg main_clock_gate,
   output reg dsp_clock_gate,
   output reg [15:0] pll_denominator,
   output reg [15:0] pll_numerator,
   output reg [6:0] pll_integer_setting,
   output reg other_wr,
   output reg param_wr,
   output reg [11:0] fwd_addr,
   output reg [7:0] fwd_wdata
);

   // spike filter length in clocks, cut to the counter width
   localparam integer FILTER_CYCLES_INT = `CCE_FILTER_CYCLES;
   localparam [3:0] FILTER_CYCLES = FILTER_CYCLES_INT[3:0];

   reg [7:0] clock_control;
   reg [7:0] den_msb;
   reg [7:0] den_lsb;
   reg [7:0] num_msb;
   reg [7:0] num_lsb;
   reg [7:0] integer_setting;
   reg param_write_locked;

   wire synth_lock_status;
   wire spi_mode;
   wire filter_bypass;
   wire [9:0] index;
   wire aligned;
   wire setup_phase;
   wire access_wr;
   wire hit_clock_control;
   wire hit_den_msb;
   wire hit_den_lsb;
   wire hit_num_msb;
   wire hit_num_lsb;
   wire hit_integer;
   wire hit_lock;
   wire hit_core_enable;
   wire hit_status;
   wire hit_pll_setup;
   wire hit_other;
   wire hit_param;
   wire mapped;
   wire gate_open;
   wire gate_rise;
   wire lock_clear;
   reg [7:0] next_clock_control;
   reg [31:0] read_mux;

   // level inputs from pins, three-stage synchronised, filter bypassed so only one-cycle pulses are dropped
   cce_glitch_filter #(
      .CYCLES(FILTER_CYCLES),
      .RESET_LEVEL(1'b0)
   ) u_lock_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(pll_lock_pin),
      .bypass(1'b1),
      .filtered(synth_lock_status)
   );

   cce_glitch_filter #(
      .CYCLES(FILTER_CYCLES),
      .RESET_LEVEL(1'b0)
   ) u_spi_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(spi_mode_pin),
      .bypass(1'b1),
      .filtered(spi_mode)
   );

   // filter off by bit or forced off in spi mode
   assign filter_bypass = clock_control[`CCE_BIT_FILTER_OFF] | spi_mode;

   cce_glitch_filter #(
      .CYCLES(FILTER_CYCLES),
      .RESET_LEVEL(1'b1)
   ) u_sda_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin(sda_pin),
      .bypass(filter_bypass),
      .filtered(sda_filtered)
   );

   cce_glitch_filter #(
      .CYCLES(FILTER_CYCLES),
      .RESET_LEVEL(1'b1)
   ) u_scl_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin(scl_pin),
      .bypass(filter_bypass),
      .filtered(scl_filtered)
   );

   // apb decode
   assign index = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign setup_phase = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   assign pready = 1'b1;

   assign hit_clock_control = aligned && index == `CCE_IDX_CLOCK_CONTROL;
   assign hit_den_msb = aligned && index == `CCE_IDX_DEN_MSB;
   assign hit_den_lsb = aligned && index == `CCE_IDX_DEN_LSB;
   assign hit_num_msb = aligned && index == `CCE_IDX_NUM_MSB;
   assign hit_num_lsb = aligned && index == `CCE_IDX_NUM_LSB;
   assign hit_integer = aligned && index == `CCE_IDX_INTEGER;
   assign hit_lock = aligned && index == `CCE_IDX_SYNTH_LOCK_STATUS;
   assign hit_core_enable = aligned && index == `CCE_IDX_CORE_ENABLE;
   assign hit_status = aligned && index == `CCE_IDX_BLOCK_STATUS;
   assign hit_pll_setup = hit_den_msb | hit_den_lsb | hit_num_msb | hit_num_lsb | hit_integer;
   assign hit_other = aligned && paddr >= `CCE_OTHER_BASE && paddr < `CCE_PARAM_BASE;
   assign hit_param = aligned && paddr >= `CCE_PARAM_BASE;
   assign mapped = hit_clock_control | hit_pll_setup | hit_lock | hit_core_enable |
                   hit_status | hit_other | hit_param;
   assign pslverr = psel & penable & ~mapped;

   // main gate low locks out everything but clock control and pll setup
   assign gate_open = clock_control[`CCE_BIT_MAIN_GATE];

   always @* begin
      next_clock_control = pwdata[7:0] & `CCE_CLOCK_CONTROL_MASK;
   end

   assign gate_rise = access_wr & hit_clock_control & ~gate_open &
                      next_clock_control[`CCE_BIT_MAIN_GATE];

   assign lock_clear = access_wr & hit_core_enable & gate_open &
                       pwdata[`CCE_BIT_DSP_CLOCK_GATE];

   // register read mux
   always @* begin
      read_mux = 32'h0000_0000;
      if (hit_clock_control) begin
         read_mux[7:0] = clock_control;
      end else if (hit_den_msb) begin
         read_mux[7:0] = den_msb;
      end else if (hit_den_lsb) begin
         read_mux[7:0] = den_lsb;
      end else if (hit_num_msb) begin
         read_mux[7:0] = num_msb;
      end else if (hit_num_lsb) begin
         read_mux[7:0] = num_lsb;
      end else if (hit_integer) begin
         read_mux[7:0] = integer_setting;
      end else if (hit_lock) begin
         read_mux[0] = synth_lock_status;
      end else if (hit_core_enable) begin
         read_mux[`CCE_BIT_DSP_CLOCK_GATE] = dsp_clock_gate;
      end else if (hit_status) begin
         read_mux[0] = param_write_locked;
         read_mux[1] = ~filter_bypass;
         read_mux[2] = spi_mode;
      end
   end

   // read data captured in the setup cycle, held through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= read_mux;
      end
   end

   // clock control, writable whatever the main gate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_control <= `CCE_CLOCK_CONTROL_RESET;
      end else if (access_wr && hit_clock_control) begin
         clock_control <= next_clock_control;
      end
   end

   // pll setup registers, writable whatever the main gate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         den_msb <= `CCE_SETUP_RESET;
      end else if (access_wr && hit_den_msb) begin
         den_msb <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         den_lsb <= `CCE_SETUP_RESET;
      end else if (access_wr && hit_den_lsb) begin
         den_lsb <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         num_msb <= `CCE_SETUP_RESET;
      end else if (access_wr && hit_num_msb) begin
         num_msb <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         num_lsb <= `CCE_SETUP_RESET;
      end else if (access_wr && hit_num_lsb) begin
         num_lsb <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integer_setting <= `CCE_SETUP_RESET;
      end else if (access_wr && hit_integer) begin
         integer_setting <= pwdata[7:0] & `CCE_INTEGER_MASK;
      end
   end

   // core enable, only with the main gate open
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsp_clock_gate <= 1'b0;
      end else if (access_wr && hit_core_enable && gate_open) begin
         dsp_clock_gate <= pwdata[`CCE_BIT_DSP_CLOCK_GATE];
      end
   end

   // parameter write lock: armed by main gate rising, freed by dsp clock gate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         param_write_locked <= 1'b0;
      end else if (gate_rise) begin
         param_write_locked <= 1'b1;
      end else if (lock_clear) begin
         param_write_locked <= 1'b0;
      end
   end

   // write pulses for other registers and parameter memory
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         other_wr <= 1'b0;
         param_wr <= 1'b0;
      end else begin
         other_wr <= access_wr & hit_other & gate_open;
         param_wr <= access_wr & hit_param & gate_open & ~param_write_locked;
      end
   end

   // forwarded address and data, loaded even when the write is refused
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_addr <= 12'h000;
         fwd_wdata <= 8'h00;
      end else if (access_wr && (hit_other || hit_param)) begin
         fwd_addr <= paddr;
         fwd_wdata <= pwdata[7:0];
      end
   end

   // pll power and output clock enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_power_up <= 1'b0;
         pll_clock_enable <= 1'b0;
      end else begin
         pll_power_up <= clock_control[`CCE_BIT_SYNTH_POWER];
         pll_clock_enable <= clock_control[`CCE_BIT_SYNTH_POWER] &
                             clock_control[`CCE_BIT_MAIN_GATE];
      end
   end

   // source, divider and gate selections
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_osc_disable <= 1'b0;
         main_source_select <= 1'b0;
         core_divider_select <= 1'b0;
         master_divider_select <= 1'b0;
         main_clock_gate <= 1'b0;
      end else begin
         xtal_osc_disable <= clock_control[`CCE_BIT_XTAL_OFF];
         main_source_select <= clock_control[`CCE_BIT_SOURCE_SEL];
         core_divider_select <= clock_control[`CCE_BIT_CORE_DIV];
         master_divider_select <= clock_control[`CCE_BIT_MASTER_DIV];
         main_clock_gate <= clock_control[`CCE_BIT_MAIN_GATE];
      end
   end

   // pll divider settings
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_denominator <= 16'h0000;
         pll_numerator <= 16'h0000;
         pll_integer_setting <= 7'h00;
      end else begin
         pll_denominator <= {den_msb, den_lsb};
         pll_numerator <= {num_msb, num_lsb};
         pll_integer_setting <= integer_setting[6:0];
      end
   end

endmodule

// File: common/cce_consts.vh
// constants for the clock control block
`ifndef CCE_CONSTS_VH
`define CCE_CONSTS_VH

`define CCE_ADDR_W 12
`define CCE_DATA_W 32

// register indices, byte address is four times the index
`define CCE_IDX_CLOCK_CONTROL 10'h000
`define CCE_IDX_DEN_MSB 10'h001
`define CCE_IDX_DEN_LSB 10'h002
`define CCE_IDX_NUM_MSB 10'h003
`define CCE_IDX_NUM_LSB 10'h004
`define CCE_IDX_INTEGER 10'h005
`define CCE_IDX_SYNTH_LOCK_STATUS 10'h006
`define CCE_IDX_CORE_ENABLE 10'h00a
`define CCE_IDX_BLOCK_STATUS 10'h00b

// forwarded write regions, byte addresses
`define CCE_OTHER_BASE 12'h040
`define CCE_PARAM_BASE 12'h400

// clock_control fields
`define CCE_BIT_SYNTH_POWER 7
`define CCE_BIT_FILTER_OFF 5
`define CCE_BIT_XTAL_OFF 4
`define CCE_BIT_SOURCE_SEL 3
`define CCE_BIT_CORE_DIV 2
`define CCE_BIT_MASTER_DIV 1
`define CCE_BIT_MAIN_GATE 0
`define CCE_CLOCK_CONTROL_RESET 8'h00
`define CCE_CLOCK_CONTROL_MASK 8'hbf
`define CCE_INTEGER_MASK 8'h7f
`define CCE_SETUP_RESET 8'h00

// core enable fields
`define CCE_BIT_DSP_CLOCK_GATE 0

// timing
`define CCE_CLK_PERIOD_NS 40
`define CCE_FILTER_NS 50
`define CCE_FILTER_CYCLES ((`CCE_FILTER_NS + `CCE_CLK_PERIOD_NS - 1) / `CCE_CLK_PERIOD_NS)

`endif

// File: rtl/cce_glitch_filter.v
// pin synchroniser with optional glitch suppression
`include "cce_consts.vh"

module cce_glitch_filter #(
   parameter [3:0] CYCLES = 4'd2,
   parameter RESET_LEVEL = 1'b1
) (
   input wire pclk,
   input wire presetn,
   input wire pin,
   input wire bypass,
   output reg filtered
);

   reg sync1;
   reg sync2;
   reg sync3;
   reg [3:0] count;
   wire agree;

   assign agree = (sync2 == sync3);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= RESET_LEVEL;
         sync2 <= RESET_LEVEL;
         sync3 <= RESET_LEVEL;
         count <= 4'h0;
         filtered <= RESET_LEVEL;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
         if (!agree || sync3 == filtered) begin
            count <= 4'h0;
         end else if (bypass || count == CYCLES - 4'd1) begin
            // level held long enough, or filter bypassed
            count <= 4'h0;
            filtered <= sync3;
         end else begin
            count <= count + 4'd1;
         end
      end
   end

endmodule

// File: test/cce_clock_control_asserts.sv
// concurrent checks on the clock control block ports
module cce_cc_asserts (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pll_power_up,
   input wire pll_clock_enable,
   input wire main_source_select,
   input wire core_divider_select,
   input wire master_divider_select,
   input wire main_clock_gate,
   input wire other_wr,
   input wire param_wr,
   input wire [11:0] fwd_addr,
   input wire [7:0] fwd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   wire acc = psel & penable & pwrite;
   wire wr0 = acc & (paddr == 12'h000);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_power; wr0 |-> ##2 pll_power_up == $past(pwdata[7], 2); endproperty
   a_power: assert property (p_power) else $error("pll power");
   property p_pllclk; pll_clock_enable == (pll_power_up && main_clock_gate); endproperty
   a_pllclk: assert property (p_pllclk) else $error("pll clock");
   property p_src; wr0 |-> ##2 main_source_select == $past(pwdata[3], 2); endproperty
   a_src: assert property (p_src) else $error("source");
   property p_cdiv; wr0 |-> ##2 core_divider_select == $past(pwdata[2], 2); endproperty
   a_cdiv: assert property (p_cdiv) else $error("core div");
   property p_mdiv; wr0 |-> ##2 master_divider_select == $past(pwdata[1], 2); endproperty
   a_mdiv: assert property (p_mdiv) else $error("master div");
   property p_gate; wr0 |-> ##2 main_clock_gate == $past(pwdata[0], 2); endproperty
   a_gate: assert property (p_gate) else $error("main gate");
   property p_refuse;
      acc && paddr >= 12'h040 ##1 !main_clock_gate |-> !other_wr && !param_wr;
   endproperty
   a_refuse: assert property (p_refuse) else $error("write not refused");
   property p_accept;
      acc && paddr >= 12'h040 && paddr < 12'h400 && paddr[1:0] == 2'b00 ##1 main_clock_gate
         |-> other_wr;
   endproperty
   a_accept: assert property (p_accept) else $error("write not accepted");
   property p_fwd;
      other_wr || param_wr |-> fwd_addr == $past(paddr) && fwd_wdata == $past(pwdata[7:0]);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forwarded write");
endmodule

bind cce_clock_control cce_cc_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pll_power_up, .pll_clock_enable, .main_source_select,
   .core_divider_select, .master_divider_select, .main_clock_gate, .other_wr, .param_wr,
   .fwd_addr, .fwd_wdata);

// File: test/tb.sv
// self-checking bench for the clock control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic pll_lock_pin = 1'h0, spi_mode_pin = 1'h0, sda_pin = 1'h1, scl_pin = 1'h1;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, lfsr = 32'h39;
   wire [31:0] prdata;
   wire pready, pslverr, sda_filtered, scl_filtered, pll_power_up, pll_clock_enable;
   wire xtal_osc_disable, main_source_select, core_divider_select, master_divider_select;
   wire main_clock_gate, dsp_clock_gate, other_wr, param_wr;
   wire [15:0] pll_denominator, pll_numerator;
   wire [6:0] pll_integer_setting;
   wire [11:0] fwd_addr;
   wire [7:0] fwd_wdata;
   int bad_count = 0, comparisons = 0, n_other = 0, n_param = 0, n_low = 0;
   logic [32:0] exp_q[$];
   cce_clock_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pll_lock_pin, .spi_mode_pin, .sda_pin, .scl_pin,
      .sda_filtered, .scl_filtered, .pll_power_up, .pll_clock_enable, .xtal_osc_disable,
      .main_source_select, .core_divider_select, .master_divider_select, .main_clock_gate,
      .dsp_clock_gate, .pll_denominator, .pll_numerator, .pll_integer_setting, .other_wr,
      .param_wr, .fwd_addr, .fwd_wdata);
   always #20 pclk = ~pclk;
   function automatic logic [31:0] step(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic rd(logic [11:0] a, logic [32:0] e);
      exp_q.push_back(e);
      apb(1'h0, a, 32'h0);
   endtask
   always @(posedge pclk) begin
      n_other += other_wr;
      n_param += param_wr;
      if (!sda_filtered || !scl_filtered) n_low++;
      if (psel && penable && pready && !pwrite)
         check("rdata", {pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      #100us;
      bad_count++;
      stop_test;
   end
   initial begin
      logic [7:0] v;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      check("reset", {pll_power_up, pll_clock_enable, main_clock_gate, dsp_clock_gate}, 33'h0);
      rd(12'h000, 33'h0);
      rd(12'h034, 33'h100000000);
      apb(1'h1, 12'h018, 32'h1);
      rd(12'h018, 33'h0);
      for (int m = 0; m < 4; m++) begin
         spi_mode_pin <= m[1];
         apb(1'h1, 12'h000, 32'(m[0]) << 5);
         repeat (4) @(posedge pclk);
         rd(12'h02c, {30'h0, m[1], !(m[0] || m[1]), 1'h0});
      end
      spi_mode_pin <= 1'h0;
      // two-cycle spike: held back by the filter, passed when it is off
      for (int f = 0; f < 2; f++) begin
         apb(1'h1, 12'h000, 32'(f) << 5);
         repeat (4) @(posedge pclk);
         n_low = 0;
         sda_pin <= 1'h0;
         scl_pin <= 1'h0;
         repeat (2) @(posedge pclk);
         sda_pin <= 1'h1;
         scl_pin <= 1'h1;
         repeat (8) @(posedge pclk);
         check("glitch", n_low != 0, 33'(f));
      end
      apb(1'h1, 12'h000, 32'h0);
      repeat (4) @(posedge pclk);
      sda_pin <= 1'h0;
      repeat (8) @(posedge pclk);
      check("level", {sda_filtered, scl_filtered}, 33'h1);
      sda_pin <= 1'h1;
      // gate low: only control and pll setup writes land
      apb(1'h1, 12'h040, 32'h5a);
      apb(1'h1, 12'h400, 32'h5a);
      apb(1'h1, 12'h028, 32'h1);
      apb(1'h1, 12'h004, 32'hc3);
      apb(1'h1, 12'h008, 32'h3c);
      apb(1'h1, 12'h00c, 32'h12);
      apb(1'h1, 12'h010, 32'h34);
      apb(1'h1, 12'h014, 32'hff);
      rd(12'h028, 33'h0);
      rd(12'h004, 33'hc3);
      check("refused", n_other + n_param, 33'h0);
      check("setup", {pll_denominator, pll_integer_setting}, {16'hc33c, 7'h7f});
      check("numerator", pll_numerator, 33'h1234);
      for (int i = 0; i < 8; i++) begin
         lfsr = step(lfsr);
         pll_lock_pin <= lfsr[8];
         repeat (4) @(posedge pclk);
         // pll taken as source only once lock is seen
         v = lfsr[7:0] & {4'hf, lfsr[8], 3'h7};
         apb(1'h1, 12'h000, {lfsr[31:8], v});
         @(negedge pclk);
         check("ctl", {pll_power_up, pll_clock_enable, xtal_osc_disable, main_source_select,
            core_divider_select, master_divider_select, main_clock_gate},
            {v[7], v[7] & v[0], v[4], v[3], v[2], v[1], v[0]});
         @(posedge pclk);
         rd(12'h000, {25'h0, v & 8'hbf});
         rd(12'h018, {32'h0, lfsr[8]});
      end
      apb(1'h1, 12'h000, 32'h0);
      apb(1'h1, 12'h000, 32'h1);
      apb(1'h1, 12'h044, 32'ha5);
      apb(1'h1, 12'h400, 32'h11);
      rd(12'h044, 33'h0);
      check("locked", {n_other[3:0], n_param[3:0], fwd_addr, fwd_wdata},
         {8'h10, 12'h400, 8'h11});
      rd(12'h02c, 33'h3);
      apb(1'h1, 12'h028, 32'h1);
      apb(1'h1, 12'h400, 32'h22);
      rd(12'h028, 33'h1);
      check("unlocked", {n_param[3:0], dsp_clock_gate, fwd_wdata}, {4'h1, 1'h1, 8'h22});
      stop_test;
   end
endmodule
